/* File: src/aid_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the
// activity/inactivity detector. Assumes inclusion by bare name only.
`ifndef AID_CFG_SVH
`define AID_CFG_SVH
`define AID_OFF_CFG      12'h000
`define AID_OFF_TIMING   12'h004
`define AID_OFF_SRC      12'h008
`define AID_OFF_ALLSRC   12'h00c
`define AID_OFF_STATUS   12'h010
`define AID_OFF_MASK     12'h014
`define AID_OFF_OUT      12'h018
`define AID_CFG_ACT_LO   0
`define AID_CFG_GLOBAL   2
`define AID_CFG_FILT     3
`define AID_CFG_LATCH    4
`define AID_CFG_STPIN    5
`define AID_CFG_PIN1     6
`define AID_CFG_PIN2     7
`define AID_TIM_LEVEL_LO 0
`define AID_TIM_WEIGHT   6
`define AID_TIM_ADUR_LO  8
`define AID_TIM_IDUR_LO  12
`define AID_CFG_RESET    32'h0000_0000
`define AID_TIM_RESET    32'h0000_0000
`define AID_SLEEP_UNIT   512
`define AID_SLEEP_SHORT  16
`endif

/* File: src/aid_detector.sv */
// Activity/inactivity detector with APB register slave and interrupt pins.
// Assumes filtered samples arrive synchronous with a one-cycle valid strobe
// per accelerometer sample period, and that the APB master is conventional.
`timescale 1ns/100ps
`include "aid_cfg.svh"

module aid_detector
  import aid_pkg::*;
#(
  parameter int DATA_W = 16  // Width of one filtered axis sample.
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_CE,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [11:0]       I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  input  wire logic              I_SAMPLE_VALID,
  input  wire logic [DATA_W-1:0] I_SLOPE_X,
  input  wire logic [DATA_W-1:0] I_SLOPE_Y,
  input  wire logic [DATA_W-1:0] I_SLOPE_Z,
  input  wire logic [DATA_W-1:0] I_HP_X,
  input  wire logic [DATA_W-1:0] I_HP_Y,
  input  wire logic [DATA_W-1:0] I_HP_Z,
  input  wire logic [7:0]        I_WEIGHT_FS,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  output logic [31:0]            O_PRDATA,
  output logic                   O_IRQ_PIN_ONE,
  output logic                   O_IRQ_PIN_TWO,
  output logic                   O_IRQ,
  output logic                   O_RATE_OVERRIDE,
  output logic [1:0]             O_GYRO_CMD
);

  // Configuration, timing, sticky status and mask registers.
  logic [31:0] cfg, next_cfg;
  logic [31:0] timing, next_timing;
  logic [1:0]  status, next_status;   // Bit0 change event, bit1 sleep entry.
  logic [1:0]  mask, next_mask;
  aid_state_t  state, next_state;     // Current activity state.
  logic [15:0] quiet_cnt, next_quiet_cnt;  // Consecutive quiet samples.
  logic [1:0]  loud_cnt, next_loud_cnt;    // Consecutive loud samples.
  logic        pulse, next_pulse;     // One-sample-period change pulse.
  logic        latched, next_latched; // Latched change flag.
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;
  logic [31:0] prdata, next_prdata;
  logic        pin1, next_pin1;
  logic        pin2, next_pin2;
  logic        irq, next_irq;
  logic        rate_ovr, next_rate_ovr;
  logic [1:0]  gyro, next_gyro;

  // Field views of the configuration registers.
  logic [1:0] inactivity_action_sel;
  logic       event_irq_global_on, detector_filter_sel, latch_request;
  logic       state_on_pin, pin_one_state_route, pin_two_state_route;
  logic [5:0] motion_level_field;
  logic       threshold_weight_bit;
  logic [1:0] activity_duration;
  logic [3:0] inactivity_duration;
  assign inactivity_action_sel = cfg[`AID_CFG_ACT_LO +: 2];
  assign event_irq_global_on   = cfg[`AID_CFG_GLOBAL];
  assign detector_filter_sel   = cfg[`AID_CFG_FILT];
  assign latch_request         = cfg[`AID_CFG_LATCH];
  assign state_on_pin          = cfg[`AID_CFG_STPIN];
  assign pin_one_state_route   = cfg[`AID_CFG_PIN1];
  assign pin_two_state_route   = cfg[`AID_CFG_PIN2];
  assign motion_level_field    = timing[`AID_TIM_LEVEL_LO +: 6];
  assign threshold_weight_bit  = timing[`AID_TIM_WEIGHT];
  assign activity_duration     = timing[`AID_TIM_ADUR_LO +: 2];
  assign inactivity_duration   = timing[`AID_TIM_IDUR_LO +: 4];

  // Magnitude of each axis of the selected filter output.
  logic [DATA_W-1:0] sel_axis [3];
  logic [DATA_W-1:0] mag [3];
  logic [2:0]        over;
  logic [DATA_W-1:0] thresh;
  logic [DATA_W+7:0] thresh_wide;

  // Threshold step: full scale / 64 or / 256. I_WEIGHT_FS is full scale
  // in sample units divided by 256, so the coarse step is four times it.
  always_comb begin
    thresh_wide = {2'b00, motion_level_field} * {8'h00, I_WEIGHT_FS};
    if (!threshold_weight_bit) begin
      thresh_wide = thresh_wide << 2;
    end
    thresh = thresh_wide[DATA_W-1:0];
  end

  // One generate loop handles the per-axis select, absolute value, compare.
  for (genvar a = 0; a < 3; a++) begin : g_axis
    always_comb begin
      sel_axis[a] = (a == 0) ? (detector_filter_sel ? I_HP_X : I_SLOPE_X) :
                    (a == 1) ? (detector_filter_sel ? I_HP_Y : I_SLOPE_Y) :
                               (detector_filter_sel ? I_HP_Z : I_SLOPE_Z);
      // Two's complement magnitude; both signs cross the level.
      mag[a] = sel_axis[a][DATA_W-1] ? (~sel_axis[a] + 1'b1)
                                     : sel_axis[a];
      over[a] = (mag[a] > thresh);
    end
  end

  // Bus decode: a read of either source register clears a latched flag.
  logic acc, wr, rd, src_read;
  assign acc      = I_PSEL && I_PENABLE && !pready;
  assign wr       = acc && I_PWRITE;
  assign rd       = acc && !I_PWRITE;
  assign src_read = rd && (I_PADDR == `AID_OFF_SRC ||
                           I_PADDR == `AID_OFF_ALLSRC);

  // Needed quiet count: 512 periods per step, or 16 for a zero field.
  logic [15:0] sleep_need;
  always_comb begin
    if (inactivity_duration == 4'h0) begin
      sleep_need = 16'(`AID_SLEEP_SHORT);
    end else begin
      sleep_need = 16'(inactivity_duration) * 16'(`AID_SLEEP_UNIT);
    end
  end

  // Detector next state: counters, transitions and change events.
  logic routed, use_latch, change;
  always_comb begin
    next_state     = state;
    next_quiet_cnt = quiet_cnt;
    next_loud_cnt  = loud_cnt;
    next_pulse     = pulse;
    change         = 1'b0;
    routed    = pin_one_state_route || pin_two_state_route;
    use_latch = latch_request && routed && !state_on_pin;
    if (!event_irq_global_on) begin
      // Detector idle and held awake while disabled.
      next_state     = AID_AWAKE;
      next_quiet_cnt = 16'h0000;
      next_loud_cnt  = 2'b00;
      next_pulse     = 1'b0;
    end else if (I_SAMPLE_VALID) begin
      next_pulse = 1'b0;  // Pulse lasts one sample period.
      if (state == AID_AWAKE) begin
        if (|over) begin
          next_quiet_cnt = 16'h0000;
        end else if (quiet_cnt + 16'h0001 >= sleep_need) begin
          next_state     = AID_ASLEEP;
          next_quiet_cnt = 16'h0000;
          change         = 1'b1;
        end else begin
          next_quiet_cnt = quiet_cnt + 16'h0001;
        end
      end else begin
        // Loud run of activity_duration+1 samples wakes; zero means one.
        if (!(|over)) begin
          next_loud_cnt = 2'b00;
        end else if (loud_cnt >= activity_duration) begin
          next_state    = AID_AWAKE;
          next_loud_cnt = 2'b00;
          change        = 1'b1;
        end else begin
          next_loud_cnt = loud_cnt + 2'b01;
        end
      end
      if (change) begin
        next_pulse = 1'b1;
      end
    end
    // Latched flag: set wins over the clearing read.
    if (change && use_latch) begin
      next_latched = 1'b1;
    end else if (src_read || !use_latch) begin
      next_latched = 1'b0;
    end else begin
      next_latched = latched;
    end
  end

  // Power overrides and pins, all registered.
  logic flag;
  always_comb begin
    flag = use_latch ? latched : pulse;
    next_rate_ovr = 1'b0;
    next_gyro     = AID_GYRO_KEEP;
    if (next_state == AID_ASLEEP) begin
      // Motion/stationary mode reports only, no power change.
      case (inactivity_action_sel)
        2'b01: begin
          next_rate_ovr = 1'b1;
        end
        2'b10: begin
          next_rate_ovr = 1'b1;
          next_gyro     = AID_GYRO_SLEEP;
        end
        2'b11: begin
          next_rate_ovr = 1'b1;
          next_gyro     = AID_GYRO_OFF;
        end
        default: begin
          next_rate_ovr = 1'b0;
        end
      endcase
    end
    // Pins show either the change flag or the sleep level.
    if (state_on_pin) begin
      next_pin1 = pin_one_state_route && (next_state == AID_ASLEEP);
      next_pin2 = pin_two_state_route && (next_state == AID_ASLEEP);
    end else begin
      next_pin1 = pin_one_state_route &&
                  (use_latch ? next_latched : next_pulse);
      next_pin2 = pin_two_state_route &&
                  (use_latch ? next_latched : next_pulse);
    end
  end

  // Register file next values and sticky status; set beats clear.
  always_comb begin
    next_cfg     = cfg;
    next_timing  = timing;
    next_mask    = mask;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    next_status  = status;
    if (acc) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (I_PADDR == `AID_OFF_CFG) begin
        next_prdata = cfg;
        if (wr) next_cfg = {24'h000000, I_PWDATA[7:0]};
      end else if (I_PADDR == `AID_OFF_TIMING) begin
        next_prdata = timing;
        if (wr) next_timing = {16'h0000, I_PWDATA[15:0]};
      end else if (I_PADDR == `AID_OFF_SRC ||
                   I_PADDR == `AID_OFF_ALLSRC) begin
        // Bit0 change flag, bit1 present sleep state.
        next_prdata = {30'h0, (state == AID_ASLEEP), flag};
      end else if (I_PADDR == `AID_OFF_STATUS) begin
        next_prdata = {30'h0, status};
        if (wr) next_status = status & ~I_PWDATA[1:0];
      end else if (I_PADDR == `AID_OFF_MASK) begin
        next_prdata = {30'h0, mask};
        if (wr) next_mask = I_PWDATA[1:0];
      end else if (I_PADDR == `AID_OFF_OUT) begin
        next_prdata = {29'h0, gyro, rate_ovr};
      end else begin
        next_pslverr = 1'b1;  // Unmapped address.
      end
    end
    if (change) begin
      next_status[0] = 1'b1;
      if (next_state == AID_ASLEEP) next_status[1] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  // All state registers; clock enable freezes everything.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg <= `AID_CFG_RESET;
      timing <= `AID_TIM_RESET;
      status <= 2'b00;
      mask <= 2'b00;
      state <= AID_AWAKE;
      quiet_cnt <= 16'h0000;
      loud_cnt <= 2'b00;
      pulse <= 1'b0;
      latched <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      pin1 <= 1'b0;
      pin2 <= 1'b0;
      irq <= 1'b0;
      rate_ovr <= 1'b0;
      gyro <= 2'b00;
    end else if (I_CE) begin
      cfg <= next_cfg;
      timing <= next_timing;
      status <= next_status;
      mask <= next_mask;
      state <= next_state;
      quiet_cnt <= next_quiet_cnt;
      loud_cnt <= next_loud_cnt;
      pulse <= next_pulse;
      latched <= next_latched;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      pin1 <= next_pin1;
      pin2 <= next_pin2;
      irq <= next_irq;
      rate_ovr <= next_rate_ovr;
      gyro <= next_gyro;
    end
  end

  assign O_PREADY        = pready;
  assign O_PSLVERR       = pslverr;
  assign O_PRDATA        = prdata;
  assign O_IRQ_PIN_ONE   = pin1;
  assign O_IRQ_PIN_TWO   = pin2;
  assign O_IRQ           = irq;
  assign O_RATE_OVERRIDE = rate_ovr;
  assign O_GYRO_CMD      = gyro;

endmodule // aid_detector

/* File: src/aid_pkg.sv */
// Types shared by the activity/inactivity detector.
// Assumes aid_cfg.svh supplies all numeric constants.
package aid_pkg;
  // Detector state: awake (activity) or asleep (inactivity).
  typedef enum logic {AID_AWAKE, AID_ASLEEP} aid_state_t;
  // Gyroscope commands driven while asleep.
  typedef enum logic [1:0] {AID_GYRO_KEEP, AID_GYRO_SLEEP,
                            AID_GYRO_OFF} aid_gyro_t;
endpackage

/* File: testbench/aid_assertions.sv */
// Checker for the activity/inactivity detector top-level ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module aid_checker (
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_SAMPLE_VALID,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_IRQ_PIN_ONE,
  input wire logic        O_RATE_OVERRIDE,
  input wire logic [1:0]  O_GYRO_CMD
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // The slave answers one cycle after the first access edge.
  pready_wait_a: assert property (I_PSEL && I_PENABLE && !O_PREADY
    |=> O_PREADY)
    else $error("ready late");
  pready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held");
  ready_cause_a: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE))
    else $error("ready unasked");
  err_data_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("error data");
  gyro_code_a: assert property (O_GYRO_CMD != 2'h3)
    else $error("gyro code");
  gyro_awake_a: assert property (!O_RATE_OVERRIDE |->
    O_GYRO_CMD == 2'h0)
    else $error("gyro not restored");
  // Rate rises follow a sample here; the bench writes the action field only while awake.
  // The override is registered at the sampling edge itself, so the
  // strobe is one cycle back when the rise is first seen.
  rate_cause_a: assert property ($rose(O_RATE_OVERRIDE) |->
    $past(I_SAMPLE_VALID))
    else $error("rate rise uncaused");
  pin_cause_a: assert property ($rose(O_IRQ_PIN_ONE) |->
    $past(I_SAMPLE_VALID) || $past(O_PREADY))
    else $error("pin rise uncaused");
  cover property ($rose(O_RATE_OVERRIDE));
  cover property ($fell(O_RATE_OVERRIDE));
  cover property (O_PSLVERR);
endmodule // aid_checker

/* File: testbench/aid_sensor_model.sv */
// Stand-in for the filter chain feeding samples to the detector.
// Assumes the bench asks for one sample with a single-cycle send strobe.
`timescale 1ns/100ps
module aid_sensor_model (
  input  wire logic        i_clk,
  input  wire logic        i_send,
  input  wire logic [15:0] i_val,
  input  wire logic [1:0]  i_axis,
  input  wire logic        i_use_hp,
  output logic             o_valid,
  output logic [15:0]      o_sx,
  output logic [15:0]      o_sy,
  output logic [15:0]      o_sz,
  output logic [15:0]      o_hx,
  output logic [15:0]      o_hy,
  output logic [15:0]      o_hz
);
  logic [15:0] noise = 16'h0; // Changes every cycle outside samples.
  logic [15:0] q_val = 16'h0;
  logic [1:0]  q_ax  = 2'h0;
  logic        q_hp  = 1'b0;
  initial o_valid = 1'b0;
  // One valid strobe a sample; data only means anything with it.
  always @(posedge i_clk) begin
    noise   <= noise + 16'h1357;
    o_valid <= i_send;
    if (i_send) begin
      q_val <= i_val;
      q_ax  <= i_axis;
      q_hp  <= i_use_hp;
    end
  end
  // The unused filter path carries a loud value, so a wrong pick shows.
  function automatic logic [15:0] pick(input logic hp, input int k);
    if (!o_valid) return noise ^ 16'(k);
    if (q_hp != hp) return 16'h7000;
    return (q_ax == 2'(k)) ? q_val : 16'h0;
  endfunction
  // A process, not continuous assigns: the function reads module state
  // that is not among its arguments, and must still be re-evaluated.
  always_comb begin
    o_sx = pick(1'b0, 0);
    o_sy = pick(1'b0, 1);
    o_sz = pick(1'b0, 2);
    o_hx = pick(1'b1, 0);
    o_hy = pick(1'b1, 1);
    o_hz = pick(1'b1, 2);
  end
endmodule // aid_sensor_model

/* File: testbench/testbench.sv */
// Self-checking bench for the detector: APB master, sample source, model.
// Assumes a 100 MHz clock and full scale of eight LSBs per fine step.
`timescale 1ns/100ps
`include "aid_cfg.svh"
module testbench;
  import aid_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, send, use_hp, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [15:0] sval, sx, sy, sz, hx, hy, hz;
  logic [1:0]  sax, gyro;
  logic        valid, pready, pslverr, pin1, pin2, irq, ovr;
  int          bad_count, num_checks, thr, act, qc, lc;
  bit          slp, glob;
  always #5 clk = ~clk;
  aid_sensor_model u_src (.i_clk(clk), .i_send(send), .i_val(sval),
    .i_axis(sax), .i_use_hp(use_hp), .o_valid(valid), .o_sx(sx),
    .o_sy(sy), .o_sz(sz), .o_hx(hx), .o_hy(hy), .o_hz(hz));
  aid_detector dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_SAMPLE_VALID(valid),
    .I_SLOPE_X(sx), .I_SLOPE_Y(sy), .I_SLOPE_Z(sz), .I_HP_X(hx),
    .I_HP_Y(hy), .I_HP_Z(hz), .I_WEIGHT_FS(8'h08), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_IRQ_PIN_ONE(pin1),
    .O_IRQ_PIN_TWO(pin2), .O_IRQ(irq), .O_RATE_OVERRIDE(ovr),
    .O_GYRO_CMD(gyro));
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Holds the request until ready is seen high at a rising edge.
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin bad_count++; close_out(); end
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  // Sends one sample and advances the reference model by it.
  task automatic smp(input bit loud);
    int m;
    m = loud ? thr + 1 + $urandom_range(0, 40) : $urandom_range(0, thr);
    if ($urandom_range(0, 1)) m = -m;
    @(posedge clk);
    send <= 1'b1; sval <= 16'(m); sax <= 2'($urandom_range(0, 2));
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    if (!glob) qc = 0;
    else if (loud) begin
      qc = 0;
      if (slp && ++lc > act) begin slp = 0; lc = 0; end
    end else begin
      lc = 0;
      if (!slp && ++qc >= 16) begin slp = 1; qc = 0; end
    end
    chk("override", 32'(ovr), 32'(slp && act != 0));
    chk("gyro", 32'(gyro), (slp && act != 0) ? act - 1 : 0);
  endtask
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; send = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; sval = 16'h0; sax = 2'h0; use_hp = 1'b0;
    bad_count = 0; num_checks = 0; qc = 0; lc = 0; slp = 0; glob = 0;
    thr = 96; act = 3;
    void'($urandom(90514));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc("cfg", `AID_OFF_CFG, `AID_CFG_RESET);
    rdc("timing", `AID_OFF_TIMING, `AID_TIM_RESET);
    rdc("unmapped", 12'h01c, 32'h0);
    chk("slverr", 32'(er), 32'h1);
    apb(1'b1, `AID_OFF_CFG, 32'h0000_0043);
    apb(1'b1, `AID_OFF_TIMING, 32'h0000_0003);
    repeat (17) smp(1'b0);
    chk("pin off", 32'(pin1), 32'h0);
    glob = 1;
    for (int a = 0; a < 4; a++) begin
      act = a; use_hp <= a[0]; thr = a[1] ? 24 : 96;
      apb(1'b1, `AID_OFF_CFG, 32'(a) | 32'h44 | (a[0] ? 32'h8 : 32'h0) |
        (a == 2 ? 32'h10 : 32'h0) | (a == 3 ? 32'h80 : 32'h0));
      apb(1'b1, `AID_OFF_TIMING, 32'h3 | (a[1] ? 32'h40 : 32'h0) | (a << 8));
      apb(1'b1, `AID_OFF_MASK, a == 1 ? 32'h0 : 32'h3);
      apb(1'b1, `AID_OFF_STATUS, 32'h3);
      apb(1'b0, `AID_OFF_SRC, 32'h0);
      repeat (16) smp(1'b0);
      chk("pin1", 32'(pin1), 32'h1);
      chk("pin2", 32'(pin2), 32'(a == 3));
      chk("irq", 32'(irq), 32'(a != 1));
      smp(1'b0);
      chk("pin1 hold", 32'(pin1), 32'(a == 2));
      rdc("src", `AID_OFF_ALLSRC, 32'h2 | 32'(a == 2));
      repeat (2) @(posedge clk);
      chk("pin1 clr", 32'(pin1), 32'h0);
      apb(1'b1, `AID_OFF_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq clr", 32'(irq), 32'h0);
      repeat (a + 1) smp(1'b1);
      chk("pin1 wake", 32'(pin1), 32'h1);
    end
    // State-on-pin with latch requested: pin shows the sleep level only.
    act = 0; use_hp <= 1'b0; thr = 96;
    apb(1'b1, `AID_OFF_CFG, 32'h0000_0074);
    apb(1'b1, `AID_OFF_TIMING, 32'h0000_0003);
    repeat (17) smp(1'b0);
    chk("pin1 level", 32'(pin1), 32'h1);
    smp(1'b1);
    chk("pin1 low", 32'(pin1), 32'h0);
    close_out();
  end
endmodule // testbench
bind aid_detector aid_checker u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA),
  .O_IRQ_PIN_ONE(O_IRQ_PIN_ONE), .O_RATE_OVERRIDE(O_RATE_OVERRIDE),
  .O_GYRO_CMD(O_GYRO_CMD));
